// [rtl/vbuf_amp_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module vbuf_amp_regs (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [vbuf_amp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [vbuf_amp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic zero_cross_in,
  output logic [vbuf_amp_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output var vbuf_amp_pkg::analog_ctrl_s ctrl,
  output logic [5:0] amp_volume_applied
);
  logic rst_meta;
  logic rst_n;
  logic [15:0] vbuf_reg;
  logic [15:0] input_reg;
  logic [15:0] gain_reg;
  logic [15:0] next_vbuf_reg;
  logic [15:0] next_input_reg;
  logic [15:0] next_gain_reg;
  logic [15:0] next_reg_rdata;
  logic next_reg_rvalid;
  logic zc_meta;
  logic zc_s2;
  logic zc_s3;
  logic zc_level;
  logic next_zc_level;
  logic zc_event;
  logic [5:0] next_volume_applied;
  logic [6:0] base_mv;

  // reset enters asynchronously, released on the clock
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // register writes
  always_comb begin
    next_vbuf_reg = vbuf_reg;
    next_input_reg = input_reg;
    next_gain_reg = gain_reg;
    if (reg_write) begin
      unique case (reg_addr)
        vbuf_amp_pkg::ADDR_VBUF: begin
          next_vbuf_reg = reg_wdata & vbuf_amp_pkg::VBUF_MASK;
        end
        vbuf_amp_pkg::ADDR_INPUT: begin
          next_input_reg = reg_wdata & vbuf_amp_pkg::INPUT_MASK;
        end
        vbuf_amp_pkg::ADDR_GAIN: begin
          next_gain_reg = reg_wdata & vbuf_amp_pkg::GAIN_MASK;
        end
        default: begin
          next_vbuf_reg = vbuf_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vbuf_reg <= vbuf_amp_pkg::VBUF_RESET;
      input_reg <= vbuf_amp_pkg::INPUT_RESET;
      gain_reg <= vbuf_amp_pkg::GAIN_RESET;
    end else begin
      vbuf_reg <= next_vbuf_reg;
      input_reg <= next_input_reg;
      gain_reg <= next_gain_reg;
    end
  end

  // read port: answer one cycle after the strobe, unmapped reads zero
  always_comb begin
    next_reg_rvalid = reg_read;
    next_reg_rdata = '0;
    if (reg_read) begin
      unique case (reg_addr)
        vbuf_amp_pkg::ADDR_VBUF: next_reg_rdata = vbuf_reg;
        vbuf_amp_pkg::ADDR_INPUT: next_reg_rdata = input_reg;
        vbuf_amp_pkg::ADDR_GAIN: next_reg_rdata = gain_reg;
        default: next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

  // zero-cross comparator is asynchronous; three stages, first one private
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      zc_meta <= 1'b0;
      zc_s2 <= 1'b0;
      zc_s3 <= 1'b0;
    end else begin
      zc_meta <= zero_cross_in;
      zc_s2 <= zc_meta;
      zc_s3 <= zc_s2;
    end
  end

  // a crossing counts once stages two and three agree on a new level
  assign zc_event = (zc_s2 == zc_s3) && (zc_s3 != zc_level);

  always_comb begin
    next_zc_level = zc_event ? zc_s3 : zc_level;
    next_volume_applied = amp_volume_applied;
    if (!gain_reg[vbuf_amp_pkg::ZC_BIT] || zc_event) begin
      next_volume_applied = gain_reg[vbuf_amp_pkg::VOL_HI:vbuf_amp_pkg::VOL_LO];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      zc_level <= 1'b0;
      amp_volume_applied <= vbuf_amp_pkg::VOL_RESET;
    end else begin
      zc_level <= next_zc_level;
      amp_volume_applied <= next_volume_applied;
    end
  end

  // offset decode; reserved codes give no offset and raise a flag
  always_comb begin
    unique case (vbuf_reg[vbuf_amp_pkg::VB_OFS_HI:vbuf_amp_pkg::VB_OFS_LO])
      vbuf_amp_pkg::OFS_40MV: base_mv = vbuf_amp_pkg::MV_40;
      vbuf_amp_pkg::OFS_20MV: base_mv = vbuf_amp_pkg::MV_20;
      default: base_mv = vbuf_amp_pkg::MV_0;
    endcase
  end

  // control fields straight from flops, except the decoded offset in mV and the reserved flags
  always_comb begin
    ctrl.vbuf_on = vbuf_reg[vbuf_amp_pkg::VB_ON_BIT];
    ctrl.vbuf_filter_boost = vbuf_reg[vbuf_amp_pkg::VB_BOOST_BIT];
    ctrl.vbuf_gain_sel = vbuf_reg[vbuf_amp_pkg::VBUF_GAIN_SEL_BIT];
    ctrl.vbuf_dc_offset_sel =
      vbuf_reg[vbuf_amp_pkg::VB_OFS_HI:vbuf_amp_pkg::VB_OFS_LO];
    ctrl.vbuf_offset_mv = ctrl.vbuf_gain_sel ? 7'(base_mv << 1) : base_mv;
    ctrl.vbuf_offset_reserved =
      (ctrl.vbuf_dc_offset_sel != vbuf_amp_pkg::OFS_40MV) &&
      (ctrl.vbuf_dc_offset_sel != vbuf_amp_pkg::OFS_20MV) &&
      (ctrl.vbuf_dc_offset_sel != vbuf_amp_pkg::OFS_0MV);
    ctrl.vbuf_pulldown = vbuf_reg[vbuf_amp_pkg::VBUF_PULLDOWN_BIT];
    ctrl.vbuf_input_clamp = vbuf_reg[vbuf_amp_pkg::VBUF_INPUT_CLAMP_BIT];
    ctrl.amp_inverting_src_sel = input_reg[vbuf_amp_pkg::INV_SRC_BIT];
    ctrl.mic_bias_level = input_reg[vbuf_amp_pkg::MICB_BIT];
    ctrl.amp_noninverting_src_sel =
      input_reg[vbuf_amp_pkg::NINV_HI:vbuf_amp_pkg::NINV_LO];
    ctrl.amp_src_reserved =
      (ctrl.amp_noninverting_src_sel != vbuf_amp_pkg::NINV_FIRST) &&
      (ctrl.amp_noninverting_src_sel != vbuf_amp_pkg::NINV_AUX);
    ctrl.amp_zero_cross_update = gain_reg[vbuf_amp_pkg::ZC_BIT];
    ctrl.amp_mute = gain_reg[vbuf_amp_pkg::MUTE_BIT];
    ctrl.amp_volume = gain_reg[vbuf_amp_pkg::VOL_HI:vbuf_amp_pkg::VOL_LO];
  end

  property p_vbuf_write;
    @(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == vbuf_amp_pkg::ADDR_VBUF) |=>
      ctrl.vbuf_on == $past(reg_wdata[7]) &&
      ctrl.vbuf_filter_boost == $past(reg_wdata[6]) &&
      ctrl.vbuf_input_clamp == $past(reg_wdata[0]);
  endproperty
  a_vbuf_write: assert property (p_vbuf_write)
    else $error("video buffer write not reflected");

  property p_gain_sel;
    @(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == vbuf_amp_pkg::ADDR_VBUF) |=>
      ctrl.vbuf_gain_sel == $past(reg_wdata[5]) &&
      ctrl.vbuf_pulldown == $past(reg_wdata[1]);
  endproperty
  a_gain_sel: assert property (p_gain_sel)
    else $error("buffer gain or pull-down wrong after write");

  property p_offset;
    @(posedge clock) disable iff (!rst_n)
    (ctrl.vbuf_dc_offset_sel == 3'h1) |->
      ctrl.vbuf_offset_mv == (ctrl.vbuf_gain_sel ? 7'h50 : 7'h28);
  endproperty
  a_offset: assert property (p_offset)
    else $error("40mV offset not scaled by gain");

  property p_mute_reset;
    @(posedge clock) $rose(rst_n) |->
      ctrl.amp_mute && ctrl.vbuf_dc_offset_sel == 3'h7 &&
      ctrl.amp_noninverting_src_sel == 2'h1 && !ctrl.vbuf_on;
  endproperty
  a_mute_reset: assert property (p_mute_reset)
    else $error("reset defaults wrong");

  property p_immediate;
    @(posedge clock) disable iff (!rst_n)
    (!ctrl.amp_zero_cross_update && !reg_write) [*2] |->
      amp_volume_applied == ctrl.amp_volume;
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("gain not applied immediately");

  property p_deferred;
    @(posedge clock) disable iff (!rst_n)
    (ctrl.amp_zero_cross_update && !zc_event) |=>
      $stable(amp_volume_applied);
  endproperty
  a_deferred: assert property (p_deferred)
    else $error("gain changed without zero cross");

  property p_unused_zero;
    @(posedge clock) disable iff (!rst_n)
    reg_rvalid |-> (reg_rdata[15:10] == 6'h00) && !reg_rdata[8];
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unassigned bits read nonzero");

  property p_read_latency;
    @(posedge clock) disable iff (!rst_n)
    (reg_read && reg_addr == vbuf_amp_pkg::ADDR_GAIN && !reg_write) |=>
      reg_rvalid && reg_rdata[5:0] == ctrl.amp_volume;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("volume read back wrong");

  property p_input_write;
    @(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == vbuf_amp_pkg::ADDR_INPUT) |=>
      ctrl.amp_inverting_src_sel == $past(reg_wdata[9]) &&
      ctrl.mic_bias_level == $past(reg_wdata[6]);
  endproperty
  a_input_write: assert property (p_input_write)
    else $error("input control write not reflected");

  property p_offset_write;
    @(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == vbuf_amp_pkg::ADDR_VBUF) |=>
      ctrl.vbuf_dc_offset_sel == $past(reg_wdata[4:2]);
  endproperty
  a_offset_write: assert property (p_offset_write)
    else $error("offset code write not reflected");

  property p_offset_twenty;
    @(posedge clock) disable iff (!rst_n)
    (ctrl.vbuf_dc_offset_sel == 3'h3) |->
      ctrl.vbuf_offset_mv == (ctrl.vbuf_gain_sel ? 7'h28 : 7'h14);
  endproperty
  a_offset_twenty: assert property (p_offset_twenty)
    else $error("20mV offset not scaled by gain");

  property p_src_write;
    @(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == vbuf_amp_pkg::ADDR_INPUT) |=>
      ctrl.amp_noninverting_src_sel == $past(reg_wdata[1:0]);
  endproperty
  a_src_write: assert property (p_src_write)
    else $error("non-inverting source write not reflected");

  property p_gain_write;
    @(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == vbuf_amp_pkg::ADDR_GAIN) |=>
      ctrl.amp_zero_cross_update == $past(reg_wdata[7]) &&
      ctrl.amp_mute == $past(reg_wdata[6]) &&
      ctrl.amp_volume == $past(reg_wdata[5:0]);
  endproperty
  a_gain_write: assert property (p_gain_write)
    else $error("gain control write not reflected");
endmodule : vbuf_amp_regs
`default_nettype wire

// [rtl/vbuf_amp_pkg.sv]
package vbuf_amp_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;

  localparam logic [6:0] ADDR_VBUF = 7'h26;
  localparam logic [6:0] ADDR_INPUT = 7'h27;
  localparam logic [6:0] ADDR_GAIN = 7'h28;

  // video buffer control fields
  localparam int VB_ON_BIT = 7;
  localparam int VB_BOOST_BIT = 6;
  localparam int VBUF_GAIN_SEL_BIT = 5;
  localparam int VB_OFS_HI = 4;
  localparam int VB_OFS_LO = 2;
  localparam int VBUF_PULLDOWN_BIT = 1;
  localparam int VBUF_INPUT_CLAMP_BIT = 0;

  // input source control fields
  localparam int INV_SRC_BIT = 9;
  localparam int MICB_BIT = 6;
  localparam int NINV_HI = 1;
  localparam int NINV_LO = 0;

  // gain control fields
  localparam int ZC_BIT = 7;
  localparam int MUTE_BIT = 6;
  localparam int VOL_HI = 5;
  localparam int VOL_LO = 0;

  localparam logic [2:0] OFS_40MV = 3'h1;
  localparam logic [2:0] OFS_20MV = 3'h3;
  localparam logic [2:0] OFS_0MV = 3'h7;
  localparam logic [1:0] NINV_FIRST = 2'h1;
  localparam logic [1:0] NINV_AUX = 2'h2;
  localparam logic [5:0] VOL_RESET = 6'h10;

  localparam logic [6:0] MV_40 = 7'h28;
  localparam logic [6:0] MV_20 = 7'h14;
  localparam logic [6:0] MV_0 = 7'h00;

  // writable masks; every other bit reads zero
  localparam logic [15:0] VBUF_MASK = 16'h00ff;
  localparam logic [15:0] INPUT_MASK = 16'h0243;
  localparam logic [15:0] GAIN_MASK = 16'h00ff;

  localparam logic [15:0] VBUF_RESET = 16'h001c;
  localparam logic [15:0] INPUT_RESET = 16'h0001;
  localparam logic [15:0] GAIN_RESET = 16'h0050;

  typedef struct packed {
    logic vbuf_on;
    logic vbuf_filter_boost;
    logic vbuf_gain_sel;
    logic [2:0] vbuf_dc_offset_sel;
    logic vbuf_pulldown;
    logic vbuf_input_clamp;
    logic [6:0] vbuf_offset_mv;
    logic vbuf_offset_reserved;
    logic amp_inverting_src_sel;
    logic mic_bias_level;
    logic [1:0] amp_noninverting_src_sel;
    logic amp_src_reserved;
    logic amp_zero_cross_update;
    logic amp_mute;
    logic [5:0] amp_volume;
  } analog_ctrl_s;
endpackage : vbuf_amp_pkg

// [test/tb_vbuf_amp_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_vbuf_amp_regs;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic zero_cross_in = 1'b0;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  vbuf_amp_pkg::analog_ctrl_s ctrl;
  logic [5:0] amp_volume_applied;
  int miscompares = 0;
  int checked = 0;
  logic [15:0] rv;
  logic [2:0] codes [4] = '{3'h1, 3'h3, 3'h7, 3'h0};
  logic [6:0] mvs [4] = '{7'h28, 7'h14, 7'h00, 7'h00};

  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); \
  end end

  vbuf_amp_regs DUT (
    .clock(clock),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .zero_cross_in(zero_cross_in),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .ctrl(ctrl),
    .amp_volume_applied(amp_volume_applied)
  );

  always #10 clock = ~clock;

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask : wr

  // read result lands on the taking edge, checked just after it
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rvalid, 1'b1)
    d = reg_rdata;
  endtask : rd

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_cycles

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end

  initial begin
    wait_cycles(8);
    resetn <= 1'b1;
    wait_cycles(3);
    rd(7'h26, rv); `CHK(rv, 16'h001c)
    rd(7'h27, rv); `CHK(rv, 16'h0001)
    rd(7'h28, rv); `CHK(rv, 16'h0050)
    `CHK(ctrl.amp_mute, 1'b1)
    `CHK(amp_volume_applied, 6'h10)
    `CHK(ctrl.vbuf_offset_mv, 7'h00)
    // all ones: unassigned bits must drop
    wr(7'h26, 16'hffff);
    `CHK({ctrl.vbuf_on, ctrl.vbuf_filter_boost}, 2'h3)
    `CHK({ctrl.vbuf_pulldown, ctrl.vbuf_input_clamp}, 2'h3)
    `CHK(ctrl.vbuf_gain_sel, 1'b1)
    rd(7'h26, rv); `CHK(rv, 16'h00ff)
    wr(7'h26, 16'h0000);
    `CHK({ctrl.vbuf_on, ctrl.vbuf_pulldown, ctrl.vbuf_input_clamp}, 3'h0)
    for (int g = 0; g < 2; g++) begin
      for (int i = 0; i < 4; i++) begin
        wr(7'h26, {10'h000, 1'(g), codes[i], 2'h0});
        `CHK(ctrl.vbuf_dc_offset_sel, codes[i])
        `CHK(ctrl.vbuf_offset_mv, 7'(mvs[i] << g))
        `CHK(ctrl.vbuf_offset_reserved, 1'(i == 3))
      end
    end
    rd(7'h26, rv); `CHK(rv, 16'h0020)
    wr(7'h27, 16'hffff);
    `CHK({ctrl.amp_inverting_src_sel, ctrl.mic_bias_level}, 2'h3)
    `CHK(ctrl.amp_src_reserved, 1'b1)
    rd(7'h27, rv); `CHK(rv, 16'h0243)
    wr(7'h27, 16'h0002);
    `CHK(ctrl.amp_noninverting_src_sel, 2'h2)
    `CHK({ctrl.amp_inverting_src_sel, ctrl.mic_bias_level}, 2'h0)
    `CHK(ctrl.amp_src_reserved, 1'b0)
    wr(7'h28, 16'hff25);
    `CHK(ctrl.amp_mute, 1'b0)
    // applied volume follows the stored code one cycle later
    wait_cycles(1);
    `CHK(amp_volume_applied, 6'h25)
    rd(7'h28, rv); `CHK(rv, 16'h0025)
    // deferred update must wait for a crossing, however long
    wr(7'h28, 16'h00bf);
    `CHK(ctrl.amp_volume, 6'h3f)
    `CHK(ctrl.amp_zero_cross_update, 1'b1)
    wait_cycles(12);
    `CHK(amp_volume_applied, 6'h25)
    zero_cross_in <= 1'b1;
    wait_cycles(8);
    `CHK(amp_volume_applied, 6'h3f)
    wr(7'h28, 16'h0080);
    wait_cycles(8);
    `CHK(amp_volume_applied, 6'h3f)
    zero_cross_in <= 1'b0;
    wait_cycles(8);
    `CHK(amp_volume_applied, 6'h00)
    wr(7'h28, 16'h0051);
    wait_cycles(1);
    `CHK(amp_volume_applied, 6'h11)
    `CHK(ctrl.amp_mute, 1'b1)
    // unmapped place: write ignored, read zero
    wr(7'h29, 16'hffff);
    rd(7'h29, rv); `CHK(rv, 16'h0000)
    rd(7'h26, rv); `CHK(rv, 16'h0020)
    // reset in mid-run restores defaults
    resetn <= 1'b0;
    wait_cycles(2);
    `CHK(ctrl.amp_volume, 6'h10)
    `CHK(ctrl.vbuf_dc_offset_sel, 3'h7)
    `CHK(ctrl.amp_noninverting_src_sel, 2'h1)
    resetn <= 1'b1;
    wait_cycles(4);
    rd(7'h28, rv); `CHK(rv, 16'h0050)
    `CHK(amp_volume_applied, 6'h10)
    rd(7'h26, rv); `CHK(rv, 16'h001c)
    wrap_up();
  end
endmodule : tb_vbuf_amp_regs
`default_nettype wire
